// >>> pin_change_pkg.sv
// Constants, register map and carrier types for the pin change detector.
// Assumes one 40 MHz system clock and an AHB-Lite word-wide register bus.
package pin_change_pkg;

	// Register indices; byte address is four times the index
	localparam logic [12:0] IDX_A_RISE   = 13'h1f3d;
	localparam logic [12:0] IDX_A_FALL   = 13'h1f3e;
	localparam logic [12:0] IDX_A_FLAG   = 13'h1f3f;
	localparam logic [12:0] IDX_B_RISE   = 13'h1f48;
	localparam logic [12:0] IDX_B_FALL   = 13'h1f49;
	localparam logic [12:0] IDX_B_FLAG   = 13'h1f4a;
	localparam logic [12:0] IDX_C_RISE   = 13'h1f53;
	localparam logic [12:0] IDX_C_FALL   = 13'h1f54;
	localparam logic [12:0] IDX_C_FLAG   = 13'h1f55;
	localparam logic [12:0] IDX_CTRL     = 13'h1f40;
	localparam logic [12:0] IDX_EVT_STAT = 13'h1f41;
	localparam logic [12:0] IDX_EVT_MASK = 13'h1f42;
	localparam logic [12:0] IDX_NONE     = 13'h1fff;

	// Implemented pin bits per port and variant
	localparam logic [7:0] MASK_A       = 8'h3f;
	localparam logic [7:0] MASK_B_LARGE = 8'hf0;
	localparam logic [7:0] MASK_B_SMALL = 8'h00;
	localparam logic [7:0] MASK_C_LARGE = 8'hff;
	localparam logic [7:0] MASK_C_SMALL = 8'h3f;

	// Field positions of the own control and event registers
	localparam int CTRL_MASTER_BIT = 0;
	localparam int EVT_EDGE_BIT    = 0;
	localparam int EVT_WAKE_BIT    = 1;

	// Register kinds seen by the address decoder
	localparam logic [2:0] KIND_RISE = 3'h0;
	localparam logic [2:0] KIND_FALL = 3'h1;
	localparam logic [2:0] KIND_FLAG = 3'h2;
	localparam logic [2:0] KIND_CTRL = 3'h3;
	localparam logic [2:0] KIND_STAT = 3'h4;
	localparam logic [2:0] KIND_MASK = 3'h5;

	// Three ports of eight pins: index 0 is A, 1 is B, 2 is C
	typedef logic [2:0][7:0] pin_bank_t;

	// Decoded register selection
	typedef struct packed {
		logic       hit;
		logic [1:0] port;
		logic [2:0] kind;
	} reg_sel_t;

	// Whole state of the block
	typedef struct packed {
		pin_bank_t   sync1;
		pin_bank_t   sync2;
		pin_bank_t   prev;
		pin_bank_t   rise;
		pin_bank_t   fall;
		pin_bank_t   flags;
		logic        master;
		logic [1:0]  evt_stat;
		logic [1:0]  evt_mask;
		logic        summary;
		logic        irq;
		logic        wake;
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
		logic        dp_wr;
		logic [12:0] dp_idx;
	} state_t;

	// Value after reset: everything clear except dp_idx at IDX_NONE, bus ready
	localparam state_t STATE_RST = '{hreadyout: 1'b1, dp_idx: IDX_NONE,
		default: '0};

endpackage

// >>> pin_change_detect.sv
// Pin edge change detector for ports A, B and C with AHB-Lite registers.
// Assumes pins are synchronous-safe inputs sampled on sys_clk, a single
// AHB-Lite master, and a sleep_mode level from the power controller.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps

module pin_change_detect #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      reset_n,
	// Port pins and power state
	input  wire pin_change_pkg::pin_bank_t pin_level,
	input  wire logic                      sleep_mode,
	// Interrupt and wake
	output logic                           change_irq_summary_flag,
	output logic                           irq,
	output logic                           wake_request,
	// AHB-Lite slave
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic [31:0]                    hrdata,
	output logic                           hresp
);

	// Registered and next state
	pin_change_pkg::state_t    s;
	pin_change_pkg::state_t    n;
	// Enabled edges seen this cycle, per pin
	pin_change_pkg::pin_bank_t edge_det;
	// Any enabled edge on any pin
	logic                      any_det;
	// Address phase of an accepted transfer
	logic                      accept;

	// Implemented bits of one port
	// Port A bits five to zero
	// Variant trims port B and C
	function automatic logic [7:0] impl_mask(input logic [1:0] port);
		logic [7:0] m;
		m = 8'h00;
		case (port)
			2'h0: m = pin_change_pkg::MASK_A;
			2'h1: m = LARGE_VARIANT ? pin_change_pkg::MASK_B_LARGE
				: pin_change_pkg::MASK_B_SMALL;
			2'h2: m = LARGE_VARIANT ? pin_change_pkg::MASK_C_LARGE
				: pin_change_pkg::MASK_C_SMALL;
			default: m = 8'h00;
		endcase
		return m;
	endfunction

	// Register index to port and kind
	function automatic pin_change_pkg::reg_sel_t decode(
		input logic [12:0] idx);
		pin_change_pkg::reg_sel_t r;
		r = '{hit: 1'b1, port: 2'h0, kind: pin_change_pkg::KIND_CTRL};
		case (idx)
			pin_change_pkg::IDX_A_RISE:   r.kind = pin_change_pkg::KIND_RISE;
			pin_change_pkg::IDX_A_FALL:   r.kind = pin_change_pkg::KIND_FALL;
			pin_change_pkg::IDX_A_FLAG:   r.kind = pin_change_pkg::KIND_FLAG;
			pin_change_pkg::IDX_B_RISE: begin
				r.kind = pin_change_pkg::KIND_RISE;
				r.port = 2'h1;
			end
			pin_change_pkg::IDX_B_FALL: begin
				r.kind = pin_change_pkg::KIND_FALL;
				r.port = 2'h1;
			end
			pin_change_pkg::IDX_B_FLAG: begin
				r.kind = pin_change_pkg::KIND_FLAG;
				r.port = 2'h1;
			end
			pin_change_pkg::IDX_C_RISE: begin
				r.kind = pin_change_pkg::KIND_RISE;
				r.port = 2'h2;
			end
			pin_change_pkg::IDX_C_FALL: begin
				r.kind = pin_change_pkg::KIND_FALL;
				r.port = 2'h2;
			end
			pin_change_pkg::IDX_C_FLAG: begin
				r.kind = pin_change_pkg::KIND_FLAG;
				r.port = 2'h2;
			end
			pin_change_pkg::IDX_CTRL:     r.kind = pin_change_pkg::KIND_CTRL;
			pin_change_pkg::IDX_EVT_STAT: r.kind = pin_change_pkg::KIND_STAT;
			pin_change_pkg::IDX_EVT_MASK: r.kind = pin_change_pkg::KIND_MASK;
			default:                      r.hit = 1'b0;
		endcase
		return r;
	endfunction

	// Per-port edge detectors
	for (genvar p = 0; p < 3; p++) begin : g_port
		// Edge from current and previous sample
		assign edge_det[p] = ((s.sync2[p] & ~s.prev[p] & s.rise[p])
			| (~s.sync2[p] & s.prev[p] & s.fall[p]))
			& impl_mask(2'(p));
	end

	// Any pin or combination may fire
	assign any_det = |edge_det;
	// Transfer taken in its address phase
	assign accept  = hsel & htrans[1] & hready;

	// Next state
	always_comb begin
		pin_change_pkg::reg_sel_t wsel;
		pin_change_pkg::reg_sel_t rsel;
		logic [7:0]               wbyte;
		logic [7:0]               rbyte;
		logic [1:0]               wp;
		logic                     wake_cond;
		// Hold every register unless changed below
		n         = s;
		// Nothing read until an address phase decodes
		rsel      = '0;
		// Data phase target from the captured index
		wsel      = decode(s.dp_idx);
		wp        = wsel.port;
		wbyte     = hwdata[7:0];
		rbyte     = 8'h00;
		wake_cond = sleep_mode & s.master & any_det;
		n.sync1   = pin_level;
		n.sync2   = s.sync1;
		n.prev    = s.sync2;
		// Data phase of a write
		if (s.dp_wr && wsel.hit) begin
			unique case (wsel.kind)
				pin_change_pkg::KIND_RISE: n.rise[wp] = wbyte & impl_mask(wp);
				pin_change_pkg::KIND_FALL: n.fall[wp] = wbyte & impl_mask(wp);
				pin_change_pkg::KIND_FLAG: n.flags[wp] = wbyte & impl_mask(wp);
				pin_change_pkg::KIND_CTRL:
					n.master = wbyte[pin_change_pkg::CTRL_MASTER_BIT];
				// Write one to clear event bits
				pin_change_pkg::KIND_STAT: n.evt_stat = s.evt_stat & ~wbyte[1:0];
				pin_change_pkg::KIND_MASK: n.evt_mask = wbyte[1:0];
				// Unused kind codes write nothing
				default: n.master = s.master;
			endcase
		end
		// Set wins over a clearing write
		n.flags = n.flags | edge_det;
		// Event bits: set wins over clear
		n.evt_stat[pin_change_pkg::EVT_EDGE_BIT] =
			n.evt_stat[pin_change_pkg::EVT_EDGE_BIT] | any_det;
		n.evt_stat[pin_change_pkg::EVT_WAKE_BIT] =
			n.evt_stat[pin_change_pkg::EVT_WAKE_BIT] | wake_cond;
		n.summary = |n.flags;
		n.irq = n.master & |(n.evt_stat & n.evt_mask);
		// Wake rises with the flag update
		n.wake = wake_cond;
		// Address phase capture
		n.dp_wr  = accept & hwrite;
		// Out-of-range addresses map to no register
		n.dp_idx = (haddr[31:15] == 17'h00000) ? haddr[14:2]
			: pin_change_pkg::IDX_NONE;
		// Read data from updated values, zero if unmapped
		rsel = decode(n.dp_idx);
		if (rsel.hit) begin
			unique case (rsel.kind)
				pin_change_pkg::KIND_RISE: rbyte = n.rise[rsel.port];
				pin_change_pkg::KIND_FALL: rbyte = n.fall[rsel.port];
				pin_change_pkg::KIND_FLAG: rbyte = n.flags[rsel.port];
				pin_change_pkg::KIND_CTRL: rbyte = {7'h00, n.master};
				pin_change_pkg::KIND_STAT: rbyte = {6'h00, n.evt_stat};
				pin_change_pkg::KIND_MASK: rbyte = {6'h00, n.evt_mask};
				default: rbyte = 8'h00;
			endcase
		end
		// Zero outside a read data phase
		n.hrdata    = (accept && !hwrite) ? {24'h000000, rbyte} : 32'h0;
		// Zero wait states, always OKAY
		n.hreadyout = 1'b1;
		n.hresp     = 1'b0;
	end

	// State register
	// Flags and enables reset to zero
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			// Clear state, bus left ready
			s <= pin_change_pkg::STATE_RST;
		end else begin
			// Advance to the computed state
			s <= n;
		end
	end

	// Outputs straight from flops
	assign change_irq_summary_flag = s.summary;
	assign irq                     = s.irq;
	assign wake_request            = s.wake;
	assign hreadyout               = s.hreadyout;
	assign hrdata                  = s.hrdata;
	assign hresp                   = s.hresp;

	// Write to port C flags in data phase
	logic wr_flag_c;
	assign wr_flag_c = s.dp_wr && (s.dp_idx == pin_change_pkg::IDX_C_FLAG);

	// All checks on the system clock, off in reset
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// Helper: summary seen high
	sequence summary_hi;
		change_irq_summary_flag;
	endsequence

	// Checks
	a_sync_depth: assert property (
		##2 s.sync2[2][0] == $past(pin_level[2][0], 2))
		else $error("pin sample not two flops deep");
	a_rise_sets: assert property (
		s.sync2[2][0] && !s.prev[2][0] && s.rise[2][0]
		|=> s.flags[2][0])
		else $error("enabled rising edge did not set flag");
	a_fall_sets: assert property (
		!s.sync2[2][1] && s.prev[2][1] && s.fall[2][1]
		|=> s.flags[2][1])
		else $error("enabled falling edge did not set flag");
	a_no_enable: assert property (
		!s.rise[0][0] && !s.fall[0][0] && !s.flags[0][0] && !s.dp_wr
		|=> !s.flags[0][0])
		else $error("flag set with detectors disabled");
	a_flag_sticky: assert property (
		s.flags[2][0] && !wr_flag_c |=> s.flags[2][0])
		else $error("flag dropped without a write");
	a_irq_gated: assert property (
		irq |-> s.master)
		else $error("request raised with master enable clear");
	a_summary_or: assert property (
		s.flags != '0 |-> change_irq_summary_flag)
		else $error("summary low while a flag is set");
	a_clear_zero: assert property (
		wr_flag_c && !hwdata[0] && !edge_det[2][0] |=> !s.flags[2][0])
		else $error("zero write did not clear flag");
	a_set_wins: assert property (
		wr_flag_c && edge_det[2][0] |=> s.flags[2][0])
		else $error("edge lost during clearing write");
	a_wake_edge: assert property (
		sleep_mode && s.master && any_det |=> wake_request ##0 summary_hi)
		else $error("no wake after enabled edge in sleep");
	a_porta_bits: assert property (
		s.rise[0][7:6] == 2'b00 && s.flags[0][7:6] == 2'b00)
		else $error("unimplemented port A bit set");
	a_small_trim: assert property (
		!LARGE_VARIANT |-> s.flags[1] == 8'h00)
		else $error("port B flag on small variant");
	// Both enables: any change on the pin sets its flag
	a_both_edges: assert property (
		s.rise[1][4] && s.fall[1][4] && s.sync2[1][4] != s.prev[1][4]
		|=> s.flags[1][4])
		else $error("edge missed with both enables set");
	// Rising edge on a pin without rise enable is ignored
	a_rise_gate: assert property (
		s.sync2[0][2] && !s.prev[0][2] && !s.rise[0][2]
		&& !s.flags[0][2] && !s.dp_wr |=> !s.flags[0][2])
		else $error("rising edge flagged without rise enable");
	// Falling edge on a pin without fall enable is ignored
	a_fall_gate: assert property (
		!s.sync2[2][0] && s.prev[2][0] && !s.fall[2][0]
		&& !s.flags[2][0] && !s.dp_wr |=> !s.flags[2][0])
		else $error("falling edge flagged without fall enable");
	// Any enabled edge records the edge event
	a_edge_status: assert property (
		any_det |=> s.evt_stat[pin_change_pkg::EVT_EDGE_BIT])
		else $error("enabled edge not recorded");
	// Master enable off: flags still set, no request
	a_master_off: assert property (
		!s.master && !s.dp_wr && any_det
		|=> !irq && change_irq_summary_flag)
		else $error("request raised or flag lost with master off");
	// Pending unmasked event with master set raises request
	a_irq_level: assert property (
		s.master && (s.evt_stat & s.evt_mask) != 2'b00 && !s.dp_wr
		|=> irq)
		else $error("request low with unmasked event pending");
	// Summary low whenever every flag is clear
	a_summary_low: assert property (
		s.flags == '0 |-> !change_irq_summary_flag)
		else $error("summary high with no flag set");
	// Flag write loads data, edges in that cycle OR in
	a_flag_write: assert property (
		wr_flag_c |=> s.flags[2]
		== $past((hwdata[7:0] | edge_det[2]) & impl_mask(2'h2)))
		else $error("port C flags differ from write plus edges");
	// Wake only after an enabled edge in sleep with master
	a_wake_pulse: assert property (
		wake_request |-> $past(sleep_mode && s.master && any_det))
		else $error("wake without enabled edge in sleep");
	// No wake follows a cycle spent awake
	a_wake_asleep: assert property (
		!sleep_mode |=> !wake_request)
		else $error("wake raised while awake");
	// Flags already hold the waking edge when wake shows
	a_wake_flags: assert property (
		wake_request |-> (s.flags & $past(edge_det)) == $past(edge_det))
		else $error("flags not updated at wake");
	// Port A fall enables above bit five stay clear
	a_porta_fall: assert property (
		s.fall[0][7:6] == 2'b00)
		else $error("unimplemented port A fall enable set");
	// Small variant has no port C bits seven and six
	a_portc_trim: assert property (
		!LARGE_VARIANT |-> s.flags[2][7:6] == 2'b00)
		else $error("port C upper flag on small variant");
	// Registers are clear on the edge after reset
	a_reset_clear: assert property (
		$past(!reset_n) |-> s.flags == '0 && s.rise == '0
		&& s.fall == '0)
		else $error("register not clear after reset");

	// Scenarios
	c_edge_irq: cover property (any_det ##1 irq);
	c_race_clear: cover property (wr_flag_c && edge_det[2][0]);
	c_sleep_wake: cover property (sleep_mode ##0 wake_request);
	c_both_edges: cover property (s.rise[1][4] && s.fall[1][4]
		&& edge_det[1][4]);

endmodule

// >>> pin_drive.sv
// Partner model: external port pins following a requested bank.
// Assumes the bench updates want just after a rising edge.
`timescale 1ns/100ps

module pin_drive (
	// Clock
	input  wire logic                      sys_clk,
	// Requested and driven levels
	input  wire pin_change_pkg::pin_bank_t want,
	output pin_change_pkg::pin_bank_t      pin_level
);
	// Pins move one edge after the request, like a slow driver
	always_ff @(posedge sys_clk) begin
		pin_level <= want;
	end
endmodule

// >>> pin_change_detect_tb.sv
// Self-checking bench for the pin change detector.
// Assumes zero-wait AHB-Lite slave and the pin partner model.
`timescale 1ns/100ps

module pin_change_detect_tb;
	logic                      sys_clk;  // System clock
	logic                      reset_n;  // Reset, active low
	logic                      sleep_mode;
	logic                      hsel, hwrite, hreadyout, hresp;
	logic                      summary, irq, wake;
	logic [1:0]                htrans;
	logic [2:0]                hsize;
	logic [31:0]               haddr, hwdata, hrdata, rd_q;
	pin_change_pkg::pin_bank_t want, pins;  // Requested, driven pins
	int                        n_errors, compares, wakes;
	logic                      wake_sum;  // Summary seen at wake

	pin_change_detect i_pin_change_detect (.sys_clk(sys_clk),
		.reset_n(reset_n), .pin_level(pins), .sleep_mode(sleep_mode),
		.change_irq_summary_flag(summary), .irq(irq),
		.wake_request(wake), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp));
	pin_drive i_pin_drive (.sys_clk(sys_clk), .want(want),
		.pin_level(pins));

	// Clock at 40 MHz
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Capture read data and wake pulses at the edge
	always @(posedge sys_clk) begin
		rd_q <= hrdata;
		if (wake === 1'b1) begin
			wakes <= wakes + 1;
			wake_sum <= summary;
		end
	end

	task automatic give_verdict;
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One single word transfer, address then data phase
	task automatic bus(input logic w, input logic [12:0] i,
		input logic [7:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {17'h0, i, 2'h0};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		#1;
	endtask

	task automatic wr(input logic [12:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
	endtask

	task automatic rd(input logic [12:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00);
		chk(rd_q, {24'h0, e});
		chk({31'h0, hresp}, 32'h0);
	endtask

	// Move one pin, then let the flag settle
	task automatic pin(input int p, input int b, input logic v);
		@(posedge sys_clk);
		want[p][b] <= v;
		repeat (5) @(posedge sys_clk);
		#1;
	endtask

	task automatic ck_irq(input logic e);
		repeat (2) @(posedge sys_clk);
		#1;
		chk(irq, e);
	endtask

	task automatic t_regs;
		rd(pin_change_pkg::IDX_A_RISE, 8'h00);
		rd(pin_change_pkg::IDX_A_FLAG, 8'h00);
		rd(pin_change_pkg::IDX_C_FLAG, 8'h00);
		rd(13'h1f43, 8'h00);
		wr(pin_change_pkg::IDX_A_RISE, 8'hff);
		rd(pin_change_pkg::IDX_A_RISE, 8'h3f);
		wr(pin_change_pkg::IDX_B_RISE, 8'hff);
		rd(pin_change_pkg::IDX_B_RISE, 8'hf0);
		wr(pin_change_pkg::IDX_A_RISE, 8'h00);
		wr(pin_change_pkg::IDX_B_RISE, 8'h00);
	endtask

	task automatic t_rise;
		wr(pin_change_pkg::IDX_C_RISE, 8'h01);
		@(posedge sys_clk);
		want[2][0] <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk(summary, 1'b0);
		@(posedge sys_clk);
		#1;
		chk(summary, 1'b1);
		rd(pin_change_pkg::IDX_C_FLAG, 8'h01);
		wr(pin_change_pkg::IDX_C_FLAG, 8'h00);
		rd(pin_change_pkg::IDX_C_FLAG, 8'h00);
		chk(summary, 1'b0);
		pin(2, 0, 1'b0);
		rd(pin_change_pkg::IDX_C_FLAG, 8'h00);
	endtask

	task automatic t_edges;
		wr(pin_change_pkg::IDX_A_FALL, 8'h04);
		pin(0, 2, 1'b1);
		rd(pin_change_pkg::IDX_A_FLAG, 8'h00);
		pin(0, 2, 1'b0);
		rd(pin_change_pkg::IDX_A_FLAG, 8'h04);
		wr(pin_change_pkg::IDX_B_RISE, 8'h10);
		wr(pin_change_pkg::IDX_B_FALL, 8'h10);
		pin(1, 4, 1'b1);
		rd(pin_change_pkg::IDX_B_FLAG, 8'h10);
		wr(pin_change_pkg::IDX_B_FLAG, 8'h00);
		pin(1, 4, 1'b0);
		rd(pin_change_pkg::IDX_B_FLAG, 8'h10);
		// Second port A flag, then clear only the known one
		wr(pin_change_pkg::IDX_A_RISE, 8'h08);
		pin(0, 3, 1'b1);
		rd(pin_change_pkg::IDX_A_FLAG, 8'h0c);
		// Read value ANDed with the inverse of the known bit
		wr(pin_change_pkg::IDX_A_FLAG, 8'h0c & ~8'h04);
		rd(pin_change_pkg::IDX_A_FLAG, 8'h08);
	endtask

	// edge lands on the edge that applies a clear
	task automatic t_race;
		@(posedge sys_clk);
		want[2][0] <= 1'b1;
		@(posedge sys_clk);
		wr(pin_change_pkg::IDX_C_FLAG, 8'h00);
		rd(pin_change_pkg::IDX_C_FLAG, 8'h01);
	endtask

	// master gate, mask and sticky event clear
	task automatic t_irq;
		// Drop the wake event; the edge event stays pending
		wr(pin_change_pkg::IDX_EVT_STAT, 8'h02);
		wr(pin_change_pkg::IDX_EVT_MASK, 8'h01);
		ck_irq(1'b0);
		wr(pin_change_pkg::IDX_CTRL, 8'h01);
		ck_irq(1'b1);
		wr(pin_change_pkg::IDX_EVT_MASK, 8'h00);
		ck_irq(1'b0);
		wr(pin_change_pkg::IDX_EVT_MASK, 8'h01);
		wr(pin_change_pkg::IDX_EVT_STAT, 8'h01);
		ck_irq(1'b0);
	endtask

	// edge in sleep wakes with flags ready
	task automatic t_sleep;
		wr(pin_change_pkg::IDX_C_FLAG, 8'h00);
		wr(pin_change_pkg::IDX_C_RISE, 8'h02);
		@(posedge sys_clk);
		sleep_mode <= 1'b1;
		pin(2, 1, 1'b1);
		chk(wakes, 1);
		chk(wake_sum, 1'b1);
		rd(pin_change_pkg::IDX_EVT_STAT, 8'h03);
		@(posedge sys_clk);
		sleep_mode <= 1'b0;
	endtask

	// Watchdog against a hang
	initial begin
		#200000;
		n_errors++;
		give_verdict;
	end

	// Main sequence
	initial begin
		n_errors = 0;
		compares = 0;
		wakes = 0;
		reset_n = 1'b0;
		sleep_mode = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		want = '0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_regs;
		t_rise;
		t_edges;
		t_race;
		t_irq;
		t_sleep;
		give_verdict;
	end
endmodule
